// ==== core/accel_params.svh ====
// constants for the accelerometer serial command readout
`ifndef ACCEL_PARAMS_SVH
`define ACCEL_PARAMS_SVH
`define CMD_MEASURE 8'h00
`define CMD_STATUS_READ 8'h0A
`define CMD_NV_RELOAD 8'h0B
`define CMD_X_SELFTEST 8'h0E
`define CMD_Y_SELFTEST 8'h0F
`define CMD_X_READ 8'h10
`define CMD_Y_READ 8'h11
`define STAT_PARITY_BIT 3
`define STAT_TEST_BIT 2
`define STAT_LOCK_BIT 1
`define STAT_PD_BIT 0
`define CMD_BITS 8
`define ACCEL_BITS 11
`define REFRESH_NS 150000
`define CLK_NS 100
`define REFRESH_CYCLES (`REFRESH_NS / `CLK_NS)
`endif

// ==== core/accel_pkg.sv ====
// types for the accelerometer serial command readout
package accel_pkg;
  typedef enum logic [2:0] {
    RESP_NONE = 3'b001,
    RESP_STATUS = 3'b010,
    RESP_ACCEL = 3'b100
  } resp_kind_t;
endpackage : accel_pkg

// ==== core/sync_level.sv ====
// two-flop synchroniser for single-bit levels
`timescale 1ns/1ps
module sync_level (
  input wire logic clk, // destination clock
  input wire logic rst_b, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic d, // asynchronous level
  output logic q // synchronised level
);
  logic meta_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : sync_level

// ==== core/accel_spi_command_readout.sv ====
// serial command decoder, status and acceleration readout of the accelerometer
// Operation
// - status bit 3 reads one when a parity fault was found, else zero
// - status bit 2 reads one while analog test mode is active
// - status bit 1 reads one while the lock register is locked
// - status bit 0 reads one while the circuit is powered down
// - reload command copies nonvolatile contents into the memory output register
// - x self-test command starts charge pump and drives x electrode
// - x self-test stays on until the measure command arrives
// - y self-test command starts charge pump and drives y electrode
// - y self-test stays on until the measure command arrives
// - x data register refreshes every 150 us in normal operation
// - no data register refresh while chip select is held low
// - x read shifts the 11-bit x word out msb first
// - y read shifts the 11-bit y word out msb first
// - y data register refreshes every 150 us unless select is low
// - commands are eight bits; measure is all zeros and the reset mode
// - status read is 0x0A, nonvolatile reload is 0x0B
// - x self-test is 0x0E, y self-test is 0x0F
// - x read is 0x10, y read is 0x11
`timescale 1ns/1ps
`include "accel_params.svh"
module accel_spi_command_readout
  import accel_pkg::*;
(
  input wire logic clk, // system clock, 10 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic ce, // clock enable, freezes the clk-domain state when low; the sck-domain link keeps running
  input wire logic sck, // serial clock from host, link domain
  input wire logic chip_select_n, // chip select, active low
  input wire logic mosi, // serial data in
  output logic miso_o, // serial data out
  output logic miso_oe, // high while miso is driven
  input wire logic [10:0] x_sample, // converted x value
  input wire logic [10:0] y_sample, // converted y value
  input wire logic parity_fault_flag, // parity checker found an error
  input wire logic analog_test_active, // analog test mode active
  input wire logic lock_closed, // lock register is locked
  input wire logic powered_down_flag, // circuit in power-down mode
  input wire logic [7:0] nv_data, // nonvolatile storage contents
  output logic [7:0] mem_out_r, // memory output register
  output logic charge_pump_en_r, // self-test charge pump on
  output logic x_selftest_hv_r, // high voltage on x electrode
  output logic y_selftest_hv_r, // high voltage on y electrode
  output logic [10:0] x_accel_r, // x acceleration data register
  output logic [10:0] y_accel_r // y acceleration data register
);
  localparam int unsigned REFRESH_CYC = `REFRESH_CYCLES;

  function automatic logic cmd_is(input logic [7:0] c, input logic [7:0] code);
    cmd_is = (c == code);
  endfunction : cmd_is

  // ---------------- link domain (sck) ----------------
  // the bit counter and command shifter run on sck; chip select resets them
  // asynchronously because sck stops between frames.
  logic [3:0] bit_cnt_r;
  logic [6:0] cmd_shift_r;
  logic [7:0] cmd_r;
  logic cmd_tgl_r;
  logic [10:0] tx_shift_r;
  logic [3:0] tx_left_r;
  resp_kind_t kind_nxt;
  logic [7:0] cmd_nxt;
  logic [7:0] status_sck;
  logic [10:0] x_sck, y_sck;
  logic [7:0] status_r;

  assign cmd_nxt = {cmd_shift_r, mosi};

  always_comb begin
    case (1'b1)
      cmd_is(cmd_nxt, `CMD_STATUS_READ): kind_nxt = RESP_STATUS;
      cmd_is(cmd_nxt, `CMD_X_READ), cmd_is(cmd_nxt, `CMD_Y_READ): kind_nxt = RESP_ACCEL;
      default: kind_nxt = RESP_NONE;
    endcase
  end

  // data registers are frozen while select is low, so sampling them here is stable
  assign x_sck = x_accel_r;
  assign y_sck = y_accel_r;
  assign status_sck = status_r;

  always_ff @(posedge sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      bit_cnt_r <= 4'h0;
      cmd_shift_r <= 7'h00;
    end else if (bit_cnt_r != 4'h8) begin
      cmd_shift_r <= cmd_nxt[6:0];
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // command word and its toggle survive the frame end for the clk domain
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r <= `CMD_MEASURE;
      cmd_tgl_r <= 1'b0;
    end else if (!chip_select_n && bit_cnt_r == 4'h7) begin
      cmd_r <= cmd_nxt;
      cmd_tgl_r <= ~cmd_tgl_r;
    end
  end

  // response shifter: loaded on the falling edge after the eighth rising edge, shifted on later falling edges
  logic load_resp_r;
  resp_kind_t kind_r;
  logic y_sel_r;
  always_ff @(posedge sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      load_resp_r <= 1'b0;
      kind_r <= RESP_NONE;
      y_sel_r <= 1'b0;
    end else if (bit_cnt_r == 4'h7) begin
      load_resp_r <= 1'b1;
      kind_r <= kind_nxt;
      y_sel_r <= cmd_nxt[0];
    end else begin
      load_resp_r <= 1'b0;
    end
  end

  always_ff @(negedge sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      tx_shift_r <= 11'h000;
      tx_left_r <= 4'h0;
    end else if (load_resp_r) begin
      case (kind_r)
        RESP_STATUS: begin
          tx_shift_r <= {status_sck, 3'b000};
          tx_left_r <= 4'h8;
        end
        RESP_ACCEL: begin
          tx_shift_r <= y_sel_r ? y_sck : x_sck;
          tx_left_r <= 4'hB;
        end
        default: begin
          tx_shift_r <= 11'h000;
          tx_left_r <= 4'h0;
        end
      endcase
    end else if (tx_left_r != 4'h0) begin
      tx_shift_r <= {tx_shift_r[9:0], 1'b0}; // msb first
      tx_left_r <= tx_left_r - 4'h1;
    end
  end

  // miso is registered on sck falling edges; outside a frame it floats
  always_ff @(negedge sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_o <= load_resp_r ? 1'b0 : tx_shift_r[10];
      miso_oe <= 1'b1;
    end
  end

  // ---------------- system domain (clk) ----------------
  // select crosses as an active-high level so its reset value matches the idle pin
  logic cs_sel_s, tgl_s;
  logic tgl_seen_r;
  logic [12:0] refresh_cnt_r;
  wire cs_n_s = ~cs_sel_s;

  sync_level u_cs_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .d(~chip_select_n),
    .q(cs_sel_s)
  );

  sync_level u_tgl_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .d(cmd_tgl_r),
    .q(tgl_s)
  );

  wire cmd_event = (tgl_s != tgl_seen_r);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_seen_r <= 1'b0;
    end else if (ce) begin
      tgl_seen_r <= tgl_s;
    end
  end

  // status snapshot; upper nibble is always zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= 8'h00;
    end else if (ce && cs_n_s) begin
      status_r <= 8'h00;
      status_r[`STAT_PARITY_BIT] <= parity_fault_flag;
      status_r[`STAT_TEST_BIT] <= analog_test_active;
      status_r[`STAT_LOCK_BIT] <= lock_closed;
      status_r[`STAT_PD_BIT] <= powered_down_flag;
    end
  end

  // cmd_r is stable once the toggle has crossed, so it is safe to read here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_out_r <= 8'h00;
    end else if (ce && cmd_event && cmd_is(cmd_r, `CMD_NV_RELOAD)) begin
      mem_out_r <= nv_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      x_selftest_hv_r <= 1'b0;
      y_selftest_hv_r <= 1'b0;
      charge_pump_en_r <= 1'b0;
    end else if (ce && cmd_event) begin
      if (cmd_is(cmd_r, `CMD_MEASURE)) begin
        x_selftest_hv_r <= 1'b0;
        y_selftest_hv_r <= 1'b0;
        charge_pump_en_r <= 1'b0;
      end else if (cmd_is(cmd_r, `CMD_X_SELFTEST)) begin
        x_selftest_hv_r <= 1'b1;
        charge_pump_en_r <= 1'b1;
      end else if (cmd_is(cmd_r, `CMD_Y_SELFTEST)) begin
        y_selftest_hv_r <= 1'b1;
        charge_pump_en_r <= 1'b1;
      end
    end
  end

  // refresh timer runs only while select is high, so a fresh sample
  // needs a full period of select high before a read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refresh_cnt_r <= 13'h0000;
    end else if (ce) begin
      if (!cs_n_s || refresh_cnt_r == 13'(REFRESH_CYC - 1)) begin
        refresh_cnt_r <= 13'h0000;
      end else begin
        refresh_cnt_r <= refresh_cnt_r + 13'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      x_accel_r <= 11'h000;
      y_accel_r <= 11'h000;
    // a refresh may land while select crosses; the link loads data much later
    end else if (ce && cs_n_s && refresh_cnt_r == 13'(REFRESH_CYC - 1)) begin
      x_accel_r <= x_sample;
      y_accel_r <= y_sample;
    end
  end

  // ---------------- checks ----------------
  property p_refresh_held;
    @(posedge clk) disable iff (!rst_b)
      (!cs_n_s && ce) |=> $stable(x_accel_r) && $stable(y_accel_r);
  endproperty
  a_refresh_held: assert property (p_refresh_held) else $error("data refreshed while selected");

  property p_x_refresh;
    @(posedge clk) disable iff (!rst_b)
      (ce && cs_n_s && refresh_cnt_r == 13'(REFRESH_CYC - 1))
        |=> x_accel_r == $past(x_sample);
  endproperty
  a_x_refresh: assert property (p_x_refresh) else $error("x data not refreshed");

  property p_y_refresh;
    @(posedge clk) disable iff (!rst_b)
      (ce && cs_n_s && refresh_cnt_r == 13'(REFRESH_CYC - 1))
        |=> y_accel_r == $past(y_sample);
  endproperty
  a_y_refresh: assert property (p_y_refresh) else $error("y data not refreshed");

  property p_measure_clears;
    @(posedge clk) disable iff (!rst_b)
      (ce && cmd_event && cmd_r == `CMD_MEASURE) |=> !x_selftest_hv_r && !y_selftest_hv_r;
  endproperty
  a_measure_clears: assert property (p_measure_clears) else $error("self-test kept on");

  property p_x_selftest;
    @(posedge clk) disable iff (!rst_b)
      (ce && cmd_event && cmd_r == `CMD_X_SELFTEST) |=> x_selftest_hv_r && charge_pump_en_r;
  endproperty
  a_x_selftest: assert property (p_x_selftest) else $error("x self-test not started");

  property p_y_selftest;
    @(posedge clk) disable iff (!rst_b)
      (ce && cmd_event && cmd_r == `CMD_Y_SELFTEST) |=> y_selftest_hv_r && charge_pump_en_r;
  endproperty
  a_y_selftest: assert property (p_y_selftest) else $error("y self-test not started");

  property p_st_hold;
    @(posedge clk) disable iff (!rst_b)
      !(ce && cmd_event && cmd_r == `CMD_MEASURE) |=>
        (x_selftest_hv_r || !$past(x_selftest_hv_r)) &&
        (y_selftest_hv_r || !$past(y_selftest_hv_r));
  endproperty
  a_st_hold: assert property (p_st_hold) else $error("self-test dropped early");

  property p_reload;
    @(posedge clk) disable iff (!rst_b)
      (ce && cmd_event && cmd_r == `CMD_NV_RELOAD) |=> mem_out_r == $past(nv_data);
  endproperty
  a_reload: assert property (p_reload) else $error("reload missed");

  property p_status_upper;
    @(posedge clk) disable iff (!rst_b) status_r[7:4] == 4'h0;
  endproperty
  a_status_upper: assert property (p_status_upper) else $error("status upper bits set");

  property p_status_flags;
    @(posedge clk) disable iff (!rst_b)
      (ce && cs_n_s) |=> status_r[3:0] ==
        {$past(parity_fault_flag), $past(analog_test_active), $past(lock_closed),
         $past(powered_down_flag)};
  endproperty
  a_status_flags: assert property (p_status_flags) else $error("status flags wrong");

endmodule : accel_spi_command_readout

// ==== test/spi_host_model.sv ====
// serial host model that issues command frames to the accelerometer readout
`timescale 1ns/1ps
module spi_host_model (
  output logic sck, // serial clock, idle low between frames
  output logic chip_select_n, // frame select, active low
  output logic mosi, // serial data to the device
  input wire logic miso_o, // serial data from the device
  input wire logic miso_oe // high while the device drives miso
);
  initial begin
    // late update so the device sees the select edge that clears its shifters
    sck <= 1'b0;
    chip_select_n <= 1'b1;
    mosi <= 1'b0;
  end

  // hp is the half period in ns: 32 for the fast link, larger for a slow host
  task automatic xfer(input logic [7:0] cmd, input int n, input int hp, output logic [10:0] resp);
    resp = 11'h000;
    chip_select_n = 1'b0;
    #150;
    for (int i = 0; i < 9 + n; i++) begin
      mosi = (i < 8) ? cmd[7 - i] : 1'b0;
      #(hp) sck = 1'b1;
      // an undriven line reads inverted so a missing drive cannot pass
      if (i >= 9) resp = {resp[9:0], (miso_oe ? miso_o : ~miso_o)};
      #(hp) sck = 1'b0;
    end
    #150 chip_select_n = 1'b1;
    mosi = 1'b0;
    #150;
  endtask : xfer

  // select held low with the clock still, as a host pausing mid-frame would
  task automatic hold_low(input int ns);
    chip_select_n = 1'b0;
    #(ns) chip_select_n = 1'b1;
  endtask : hold_low
endmodule : spi_host_model

// ==== test/testbench.sv ====
// self-checking bench for the accelerometer serial command readout
`timescale 1ns/1ps
`include "accel_params.svh"
module testbench;
  typedef struct {string nm; logic [10:0] v;} note_t;
  logic clk = 1'b0;
  logic rst_b;
  logic ce = 1'b1;
  logic [3:0] st = 4'h0;
  logic [10:0] xs = 11'h000;
  logic [10:0] ys = 11'h000;
  logic [7:0] nv = 8'h00;
  wire sck, cs_n, mosi, miso_o, miso_oe, cp, xhv, yhv;
  wire [7:0] mem_out;
  wire [10:0] xa, ya;
  integer seed = 32'h8A24;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  note_t q[$];
  logic [10:0] seen;
  event got;

  accel_spi_command_readout uut (.clk(clk), .rst_b(rst_b), .ce(ce), .sck(sck),
    .chip_select_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
    .x_sample(xs), .y_sample(ys), .parity_fault_flag(st[3]), .analog_test_active(st[2]),
    .lock_closed(st[1]), .powered_down_flag(st[0]), .nv_data(nv), .mem_out_r(mem_out),
    .charge_pump_en_r(cp), .x_selftest_hv_r(xhv), .y_selftest_hv_r(yhv),
    .x_accel_r(xa), .y_accel_r(ya));

  spi_host_model host (.sck(sck), .chip_select_n(cs_n), .mosi(mosi), .miso_o(miso_o),
    .miso_oe(miso_oe));

  initial forever #50 clk = ~clk;

  task automatic end_sim;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // the watcher pairs each appearing result with the oldest note
  initial begin
    note_t n;
    forever begin
      @(got);
      n = q.pop_front();
      compares++;
      if (seen !== n.v) begin
        $display("CHECK FAILED %s expected %h seen %h", n.nm, n.v, seen);
        err_total++;
      end
    end
  end

  task automatic note(input string nm, input logic [10:0] e);
    q.push_back('{nm, e});
  endtask : note

  task automatic show(input logic [10:0] s);
    seen = s;
    -> got;
    #1;
  endtask : show

  task automatic frame(input logic [7:0] cmd, input int n, input int hp, input string nm,
                       input logic [10:0] e);
    logic [10:0] r;
    note(nm, e);
    host.xfer(cmd, n, hp, r);
    show(r);
  endtask : frame

  task automatic go(input logic [7:0] cmd);
    logic [10:0] r;
    host.xfer(cmd, 0, 32, r);
  endtask : go

  // control outputs cross from the link, so give them a few system clocks
  task automatic st_chk(input logic [2:0] e);
    repeat (10) @(posedge clk);
    note("selftest_ctl", {8'h00, e});
    show({8'h00, cp, xhv, yhv});
  endtask : st_chk

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_sim;
    end
  end

  initial begin
    logic [10:0] a;
    logic [10:0] b;
    // reset falls from unknown so the link-side flops see an edge too
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    st_chk(3'b000);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk) st <= 4'(i);
      repeat (5) @(posedge clk);
      frame(`CMD_STATUS_READ, 8, 32, "status", {7'h00, 4'(i)});
    end
    @(posedge clk) nv <= 8'($random(seed));
    go(`CMD_NV_RELOAD);
    repeat (10) @(posedge clk);
    note("mem_out", {3'b000, nv});
    show({3'b000, mem_out});
    go(`CMD_X_SELFTEST);
    st_chk(3'b110);
    go(`CMD_STATUS_READ);
    st_chk(3'b110);
    go(`CMD_Y_SELFTEST);
    st_chk(3'b111);
    go(`CMD_MEASURE);
    st_chk(3'b000);
    // a command sent while the enable is low only takes effect once it returns
    @(posedge clk) ce <= 1'b0;
    go(`CMD_X_SELFTEST);
    st_chk(3'b000);
    @(posedge clk) ce <= 1'b1;
    st_chk(3'b110);
    go(`CMD_MEASURE);
    st_chk(3'b000);
    @(posedge clk) begin
      xs <= 11'($random(seed));
      ys <= 11'($random(seed));
    end
    repeat (`REFRESH_CYCLES + 10) @(posedge clk);
    frame(`CMD_X_READ, 11, 32, "x_word", xs);
    repeat (`REFRESH_CYCLES + 10) @(posedge clk);
    frame(`CMD_Y_READ, 11, 500, "y_word", ys);
    a = xs;
    b = ys;
    // new samples arrive only once select is already low
    fork
      host.hold_low(200000);
      begin
        repeat (5) @(posedge clk);
        xs <= ~a;
        ys <= ~b;
      end
    join
    note("x_held", a);
    show(xa);
    note("y_held", b);
    show(ya);
    repeat (`REFRESH_CYCLES + 10) @(posedge clk);
    note("x_reg", ~a);
    show(xa);
    frame(`CMD_Y_READ, 11, 32, "y_word_new", ~b);
    end_sim;
  end
endmodule : testbench
